// ===== hdl/vdo_defs.vh
`ifndef VDO_DEFS_VH
`define VDO_DEFS_VH
// register byte offsets
`define VDO_OFF_FMT    12'h000
`define VDO_OFF_STD    12'h004
`define VDO_OFF_OSEL   12'h008
`define VDO_OFF_STAT   12'h00c
// reset values
`define VDO_FMT_RST    8'h00
`define VDO_STD_RST    8'h00
`define VDO_OSEL_RST   8'h00
// format_config_reg fields
`define VDO_FMT_REGCTL 0
`define VDO_FMT_SMP_LO 1
`define VDO_FMT_411    5
`define VDO_FMT_OF_LO  6
// standard_config_reg fields
`define VDO_STD_PAL    0
`define VDO_STD_SYN_LO 1
`define VDO_STD_AUTO   7
// status_output_select and status fields
`define VDO_OSEL_CSYNC 0
`define VDO_STAT_OVF   0
// output formats
`define VDO_OF_656     2'h0
`define VDO_OF_8       2'h1
`define VDO_OF_16      2'h2
`define VDO_OF_RGB     2'h3
// sampling modes
`define VDO_SM_601     3'h0
`define VDO_SM_SQ      3'h1
`define VDO_SM_4FSC    3'h2
// sync modes
`define VDO_SY_FMA     2'h2
`define VDO_SY_FMB     2'h3
// bus slave addresses
`define VDO_ADDR_LO    7'h41
`define VDO_ADDR_HI    7'h43
// line timing, pixels per line total and active
`define VDO_HT_N601    11'd858
`define VDO_HT_P601    11'd864
`define VDO_HT_NSQ     11'd780
`define VDO_HT_PSQ     11'd944
`define VDO_HT_4FSC    11'd910
`define VDO_HA_601     11'd720
`define VDO_HA_NSQ     11'd640
`define VDO_HA_WIDE    11'd768
// field timing, lines per field total and active
`define VDO_VT_N       10'd262
`define VDO_VT_P       10'd312
`define VDO_VA_N       10'd240
`define VDO_VA_P       10'd288
// sync pulse widths
`define VDO_HS_LEN     11'd64
`define VDO_VS_LINES   10'd3
`endif

// ===== hdl/vdo_output_port.v
// Contract
// - format pins pick 656, 8, 16 or RGB
// - standard select: 0 NTSC, 1 PAL
// - auto recognition overrides pin at 601 rate
// - sampling pin 601/square; 4fsc register only
// - pin or register control, pins after reset
// - blue bus driven only in RGB
// - main bus: YCbCr, luma or green
// - chroma bus: off, CbCr or red
// - 4:2:2 chroma, limited 4:1:1
// - field flag high on odd field
// - pixel flag high in active pixels
// - line flag high in active lines
// - rate pin: 0 double, 1 normal
// - pixel clock half or equal system clock
// - system clock passed out undivided
// - sleep pin 1 enters low power
// - four sync modes, two fifo two memory
// - closed caption bytes out in vblank
// - slave address follows address select pin
// - status pin: overflow or composite sync
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "vdo_defs.vh"
module vdo_output_port #(
    parameter DW = 8
) (
    input  wire          CLK,
    input  wire          RST_N,
    input  wire          PSEL,
    input  wire          PENABLE,
    input  wire          PWRITE,
    input  wire [11:0]   PADDR,
    input  wire [31:0]   PWDATA,
    output reg  [31:0]   PRDATA,
    output wire          PREADY,
    output wire          PSLVERR,
    input  wire          SYSTEM_CLOCK_IN,
    input  wire          CLOCK_RATE_SELECT,
    input  wire [1:0]    FORMAT_SELECT,
    input  wire          STANDARD_SELECT,
    input  wire          SAMPLING_SELECT,
    input  wire          SLEEP,
    input  wire          ADDR_SELECT,
    input  wire [DW-1:0] PIX_Y,
    input  wire [DW-1:0] PIX_CB,
    input  wire [DW-1:0] PIX_CR,
    input  wire [DW-1:0] PIX_R,
    input  wire [DW-1:0] PIX_G,
    input  wire [DW-1:0] PIX_B,
    input  wire          DETECTED_PAL,
    input  wire          FIFO_OVERFLOW,
    input  wire          CC_VALID,
    input  wire [DW-1:0] CC_DATA,
    output wire          SYSTEM_CLOCK_OUT,
    output wire          PIXEL_CLOCK_OUT,
    output wire [DW-1:0] Y_DATA,
    output wire          Y_OE_N,
    output wire [DW-1:0] C_DATA,
    output wire          C_OE_N,
    output wire [DW-1:0] B_DATA,
    output wire          B_OE_N,
    output wire          FIELD_ODD,
    output wire          ACTIVE_PIXEL_FLAG,
    output wire          ACTIVE_LINE_FLAG,
    output wire          HSYNC_N,
    output wire          VSYNC_N,
    output wire          STATUS_OUT,
    output wire [3:0]    MEM_CTRL
);
    // pin synchronisers: stage one feeds stage two only
    reg  [7:0] sync1_reg;
    reg  [7:0] sync2_reg;
    reg        clk_dly_reg;
    wire [7:0] pins_raw = {SYSTEM_CLOCK_IN, CLOCK_RATE_SELECT,
                           FORMAT_SELECT, STANDARD_SELECT,
                           SAMPLING_SELECT, SLEEP, ADDR_SELECT};
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_reg   <= 8'h00;
            sync2_reg   <= 8'h00;
            clk_dly_reg <= 1'b0;
        end else begin
            sync1_reg   <= pins_raw;
            sync2_reg   <= sync1_reg;
            clk_dly_reg <= sync2_reg[7];
        end
    end
    wire       sclk     = sync2_reg[7];
    wire       rate_nrm = sync2_reg[6];
    wire [1:0] pin_fmt  = sync2_reg[5:4];
    wire       pin_std  = sync2_reg[3];
    wire       pin_smp  = sync2_reg[2];
    wire       sleep    = sync2_reg[1];
    wire       addr_sel = sync2_reg[0];
    wire       sclk_up  = sclk & ~clk_dly_reg;

    // raw clock straight through, no division
    assign SYSTEM_CLOCK_OUT = SYSTEM_CLOCK_IN;

    // registers
    reg  [7:0] fmt_reg;
    reg  [7:0] std_reg;
    reg  [7:0] osel_reg;
    reg        ovf_reg;
    reg        field_reg;
    wire       wr_en = PSEL & PENABLE & PWRITE;
    wire       acc   = PSEL & PENABLE;
    wire       mapped = (PADDR == `VDO_OFF_FMT) | (PADDR == `VDO_OFF_STD)
                      | (PADDR == `VDO_OFF_OSEL) | (PADDR == `VDO_OFF_STAT);
    wire       ovf_clr = wr_en & (PADDR == `VDO_OFF_STAT)
                       & PWDATA[`VDO_STAT_OVF];

    // control selection, pins win until the register bit is set
    wire       reg_ctl = fmt_reg[`VDO_FMT_REGCTL];
    wire [1:0] ofmt = reg_ctl ? fmt_reg[`VDO_FMT_OF_LO+:2] : pin_fmt;
    wire [2:0] smp  = reg_ctl ? fmt_reg[`VDO_FMT_SMP_LO+:3]
                              : {2'b00, pin_smp};
    wire       std_sel = reg_ctl ? std_reg[`VDO_STD_PAL] : pin_std;
    wire       auto_on = std_reg[`VDO_STD_AUTO] & (smp == `VDO_SM_601);
    // 4fsc exists for NTSC only, so it forces the NTSC timing
    wire       pal = (auto_on ? DETECTED_PAL : std_sel)
                   & (smp != `VDO_SM_4FSC);
    wire [1:0] sync_mode = std_reg[`VDO_STD_SYN_LO+:2];
    wire       fm_mode = sync_mode[1];
    wire       q411 = fmt_reg[`VDO_FMT_411];
    wire [6:0] slave_addr = addr_sel ? `VDO_ADDR_HI : `VDO_ADDR_LO;

    // apb slave: zero wait, unmapped gives error and zero data
    assign PREADY  = 1'b1;
    assign PSLVERR = acc & ~mapped;
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            fmt_reg  <= `VDO_FMT_RST;
            std_reg  <= `VDO_STD_RST;
            osel_reg <= `VDO_OSEL_RST;
        end else if (wr_en) begin
            case (PADDR)
                `VDO_OFF_FMT:  fmt_reg  <= PWDATA[7:0];
                `VDO_OFF_STD:  std_reg  <= PWDATA[7:0];
                `VDO_OFF_OSEL: osel_reg <= PWDATA[7:0];
                default:       fmt_reg  <= fmt_reg;
            endcase
        end
    end

    // read data staged in the setup cycle so it is a flop in access
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            PRDATA <= 32'h00000000;
        end else if (PSEL & ~PENABLE) begin
            case (PADDR)
                `VDO_OFF_FMT:  PRDATA <= {24'h000000, fmt_reg};
                `VDO_OFF_STD:  PRDATA <= {24'h000000, std_reg};
                `VDO_OFF_OSEL: PRDATA <= {24'h000000, osel_reg};
                `VDO_OFF_STAT: PRDATA <= {17'h00000, slave_addr, 4'h0,
                                          sleep, pal, field_reg, ovf_reg};
                default:       PRDATA <= 32'h00000000;
            endcase
        end
    end

    // overflow flag: a new event beats a clear in the same cycle
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ovf_reg <= 1'b0;
        end else if (FIFO_OVERFLOW & ~fm_mode) begin
            ovf_reg <= 1'b1;
        end else if (ovf_clr) begin
            ovf_reg <= 1'b0;
        end
    end

    // pixel clock from sampled system clock edges
    reg  pclk_reg;
    reg  div_reg;
    wire tick = sclk_up & (rate_nrm | ~div_reg) & ~sleep;
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pclk_reg <= 1'b0;
            div_reg  <= 1'b0;
        end else if (sleep) begin
            pclk_reg <= 1'b0;
            div_reg  <= 1'b0;
        end else if (rate_nrm) begin
            pclk_reg <= sclk;
            div_reg  <= 1'b0;
        end else if (sclk_up) begin
            div_reg  <= ~div_reg;
            pclk_reg <= ~div_reg;
        end
    end
    assign PIXEL_CLOCK_OUT = pclk_reg;

    // line and field geometry per standard and sampling
    reg [10:0] htot;
    reg [10:0] hact;
    always @* begin
        htot = pal ? `VDO_HT_P601 : `VDO_HT_N601;
        hact = `VDO_HA_601;
        case (smp)
            `VDO_SM_SQ: begin
                htot = pal ? `VDO_HT_PSQ : `VDO_HT_NSQ;
                hact = pal ? `VDO_HA_WIDE : `VDO_HA_NSQ;
            end
            `VDO_SM_4FSC: begin
                htot = `VDO_HT_4FSC;
                hact = `VDO_HA_WIDE;
            end
            default: begin
                htot = pal ? `VDO_HT_P601 : `VDO_HT_N601;
                hact = `VDO_HA_601;
            end
        endcase
    end
    wire [9:0]  vtot   = pal ? `VDO_VT_P : `VDO_VT_N;
    wire [9:0]  vstart = vtot - (pal ? `VDO_VA_P : `VDO_VA_N);
    wire [10:0] hstart = htot - hact;

    // timing counters; byte formats spend two ticks per pixel
    reg  [10:0] hcnt_reg;
    reg  [9:0]  vcnt_reg;
    reg         phase_reg;
    wire        mux8 = ~ofmt[1];
    wire        step = ~mux8 | phase_reg;
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            hcnt_reg  <= 11'h000;
            vcnt_reg  <= 10'h000;
            phase_reg <= 1'b0;
            field_reg <= 1'b1;
        end else if (tick) begin
            phase_reg <= mux8 & ~phase_reg;
            if (step) begin
                if (hcnt_reg >= htot - 11'h001) begin
                    hcnt_reg <= 11'h000;
                    if (vcnt_reg >= vtot - 10'h001) begin
                        vcnt_reg  <= 10'h000;
                        field_reg <= ~field_reg;
                    end else begin
                        vcnt_reg <= vcnt_reg + 10'h001;
                    end
                end else begin
                    hcnt_reg <= hcnt_reg + 11'h001;
                end
            end
        end
    end

    wire h_act = hcnt_reg >= hstart;
    wire v_act = vcnt_reg >= vstart;
    wire [1:0] bidx = {hcnt_reg[0], phase_reg};
    wire eav = hcnt_reg < 11'h002;
    wire sav = (hcnt_reg >= hstart - 11'h002) & ~h_act;
    // timing reference word: field, vblank, hblank and protection bits
    wire fb = ~field_reg;
    wire vb = ~v_act;
    wire hb = eav;
    wire [7:0] xy = {1'b1, fb, vb, hb, vb ^ hb, fb ^ hb, fb ^ vb,
                     fb ^ vb ^ hb};

    // chroma hold for the limited 4:1:1 mode
    reg [DW-1:0] cb_hold_reg;
    reg [DW-1:0] cr_hold_reg;
    reg [DW-1:0] cc_reg;
    reg          cc_full_reg;
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cb_hold_reg <= {DW{1'b0}};
            cr_hold_reg <= {DW{1'b0}};
        end else if (tick & step & (hcnt_reg[1:0] == 2'h3)) begin
            cb_hold_reg <= PIX_CB;
            cr_hold_reg <= PIX_CR;
        end
    end
    wire [DW-1:0] cb = q411 ? cb_hold_reg : PIX_CB;
    wire [DW-1:0] cr = q411 ? cr_hold_reg : PIX_CR;
    wire          crsel = q411 ? hcnt_reg[1] : hcnt_reg[0];
    wire [DW-1:0] cmux = crsel ? cr : cb;

    // closed caption byte waits for the next blanking line
    wire cc_out = ~v_act & h_act & cc_full_reg;
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cc_reg      <= {DW{1'b0}};
            cc_full_reg <= 1'b0;
        end else if (CC_VALID) begin
            cc_reg      <= CC_DATA;
            cc_full_reg <= 1'b1;
        end else if (tick & step & cc_out
                     & (hcnt_reg >= htot - 11'h001)) begin
            cc_full_reg <= 1'b0;
        end
    end

    // next bus values
    reg [DW-1:0] y_next;
    reg [DW-1:0] c_next;
    reg [DW-1:0] b_next;
    always @* begin
        c_next = {DW{1'b0}};
        b_next = {DW{1'b0}};
        if (cc_out) begin
            y_next = cc_reg;
        end else if (h_act & v_act) begin
            case (ofmt)
                `VDO_OF_16: begin
                    y_next = PIX_Y;
                    c_next = cmux;
                end
                `VDO_OF_RGB: begin
                    y_next = PIX_G;
                    c_next = PIX_R;
                    b_next = PIX_B;
                end
                default: y_next = phase_reg ? PIX_Y : cmux;
            endcase
        end else if (ofmt == `VDO_OF_656 && (eav || sav)) begin
            case (bidx)
                2'h0:    y_next = 8'hff;
                2'h1:    y_next = 8'h00;
                2'h2:    y_next = 8'h00;
                default: y_next = xy;
            endcase
        end else if (ofmt == `VDO_OF_656) begin
            y_next = phase_reg ? 8'h10 : 8'h80;
        end else begin
            y_next = 8'h00;
        end
    end

    // output flops, all changed on the tick that raises pixel clock
    reg [DW-1:0] y_reg;
    reg [DW-1:0] c_reg;
    reg [DW-1:0] b_reg;
    reg          hflag_reg;
    reg          vflag_reg;
    reg          odd_reg;
    reg          hs_reg;
    reg          vs_reg;
    reg          stat_reg;
    reg [3:0]    mem_reg;
    wire         hs_n = ~(hcnt_reg < `VDO_HS_LEN);
    wire         vs_n = ~(vcnt_reg < `VDO_VS_LINES);
    wire         wr_on = h_act & v_act;
    wire         top = (hcnt_reg == 11'h000);
    // second memory mode reads back one line behind the write
    wire         rd_line = (sync_mode == `VDO_SY_FMB);
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            y_reg     <= {DW{1'b0}};
            c_reg     <= {DW{1'b0}};
            b_reg     <= {DW{1'b0}};
            hflag_reg <= 1'b0;
            vflag_reg <= 1'b0;
            odd_reg   <= 1'b1;
            hs_reg    <= 1'b1;
            vs_reg    <= 1'b1;
            stat_reg  <= 1'b0;
            mem_reg   <= 4'h0;
        end else if (tick) begin
            y_reg     <= y_next;
            c_reg     <= c_next;
            b_reg     <= b_next;
            hflag_reg <= h_act;
            vflag_reg <= v_act;
            odd_reg   <= field_reg;
            hs_reg    <= hs_n;
            vs_reg    <= vs_n;
            // composite sync is low while either sync is low
            stat_reg  <= osel_reg[`VDO_OSEL_CSYNC] ? (hs_n & vs_n)
                                                   : ovf_reg;
            mem_reg   <= fm_mode ? {wr_on, wr_on,
                          top & (vcnt_reg == {9'h000, rd_line}),
                          top & (vcnt_reg == 10'h000)} : 4'h0;
        end
    end

    // bus enables, active low; sleep floats every data bus
    assign Y_OE_N = sleep;
    assign C_OE_N = sleep | mux8;
    assign B_OE_N = sleep | (ofmt != `VDO_OF_RGB);
    assign Y_DATA = y_reg;
    assign C_DATA = c_reg;
    assign B_DATA = b_reg;
    assign FIELD_ODD         = odd_reg;
    assign ACTIVE_PIXEL_FLAG = hflag_reg;
    assign ACTIVE_LINE_FLAG  = vflag_reg;
    assign HSYNC_N    = hs_reg;
    assign VSYNC_N    = vs_reg;
    assign STATUS_OUT = stat_reg;
    assign MEM_CTRL   = mem_reg;
endmodule

// ===== testbench/vdo_output_port_bench.sv
`timescale 1ns/100ps
`include "vdo_defs.vh"
module vdo_output_port_bench;
    logic        CLK, RST_N, PSEL, PENABLE, PWRITE;
    logic [11:0] PADDR;
    logic [31:0] PWDATA;
    logic        CLOCK_RATE_SELECT, STANDARD_SELECT, SAMPLING_SELECT, SLEEP;
    logic        ADDR_SELECT, DETECTED_PAL, FIFO_OVERFLOW, CC_VALID;
    logic [1:0]  FORMAT_SELECT;
    logic [7:0]  PIX_Y, PIX_CB, PIX_CR, PIX_R, PIX_G, PIX_B, CC_DATA;
    wire  [31:0] PRDATA, line_pixels, lines_done;
    wire  [7:0]  Y_DATA, C_DATA, B_DATA, first_y;
    wire         PREADY, PSLVERR, SYSTEM_CLOCK_IN, SYSTEM_CLOCK_OUT;
    wire         PIXEL_CLOCK_OUT, Y_OE_N, C_OE_N, B_OE_N, FIELD_ODD, HSYNC_N;
    wire         ACTIVE_PIXEL_FLAG, ACTIVE_LINE_FLAG, VSYNC_N, STATUS_OUT;
    wire  [3:0]  MEM_CTRL;
    int          err_total, n_tests, ns, np, d;
    logic [31:0] px, rd, cc;
    logic [31:0] exp_reg [4];
    logic        er;
    vdo_output_port u_vdo_output_port (
        .CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR),
        .SYSTEM_CLOCK_IN(SYSTEM_CLOCK_IN),
        .CLOCK_RATE_SELECT(CLOCK_RATE_SELECT), .FORMAT_SELECT(FORMAT_SELECT),
        .STANDARD_SELECT(STANDARD_SELECT), .SAMPLING_SELECT(SAMPLING_SELECT),
        .SLEEP(SLEEP), .ADDR_SELECT(ADDR_SELECT), .PIX_Y(PIX_Y),
        .PIX_CB(PIX_CB), .PIX_CR(PIX_CR), .PIX_R(PIX_R), .PIX_G(PIX_G),
        .PIX_B(PIX_B), .DETECTED_PAL(DETECTED_PAL),
        .FIFO_OVERFLOW(FIFO_OVERFLOW), .CC_VALID(CC_VALID),
        .CC_DATA(CC_DATA), .SYSTEM_CLOCK_OUT(SYSTEM_CLOCK_OUT),
        .PIXEL_CLOCK_OUT(PIXEL_CLOCK_OUT), .Y_DATA(Y_DATA), .Y_OE_N(Y_OE_N),
        .C_DATA(C_DATA), .C_OE_N(C_OE_N), .B_DATA(B_DATA), .B_OE_N(B_OE_N),
        .FIELD_ODD(FIELD_ODD), .ACTIVE_PIXEL_FLAG(ACTIVE_PIXEL_FLAG),
        .ACTIVE_LINE_FLAG(ACTIVE_LINE_FLAG), .HSYNC_N(HSYNC_N),
        .VSYNC_N(VSYNC_N), .STATUS_OUT(STATUS_OUT), .MEM_CTRL(MEM_CTRL));
    vdo_rx_model u_vdo_rx_model (
        .rst_n(RST_N), .pclk(PIXEL_CLOCK_OUT), .active(ACTIVE_PIXEL_FLAG),
        .y_data(Y_DATA), .sys_clk(SYSTEM_CLOCK_IN),
        .line_pixels(line_pixels), .lines_done(lines_done),
        .first_y(first_y));
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer; write data also updates the register model
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] v);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= v;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        if (wr && a < 12'h00c)
            exp_reg[a[3:2]] = {24'h0, v[7:0]};
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
    endtask
    // counts system and pixel clock rises over a fixed span
    task automatic rate();
        logic s0, p0;
        ns = 0;
        np = 0;
        s0 = SYSTEM_CLOCK_IN;
        p0 = PIXEL_CLOCK_OUT;
        repeat (1000) begin
            @(posedge CLK);
            if (SYSTEM_CLOCK_IN && !s0) ns++;
            if (PIXEL_CLOCK_OUT && !p0) np++;
            s0 = SYSTEM_CLOCK_IN;
            p0 = PIXEL_CLOCK_OUT;
        end
        d = (CLOCK_RATE_SELECT ? ns : ns / 2) - np;
    endtask
    task automatic report_and_stop();
        if (err_total == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end
    // pixel inputs move every cycle so stale data cannot pass unseen
    always @(posedge CLK) begin
        px <= lfsr_next(px);
        {PIX_Y, PIX_CB, PIX_CR, PIX_R} <= px;
        {PIX_G, PIX_B} <= px[19:4];
    end
    // a full run needs about 17k cycles; this leaves ample margin
    initial begin
        #700000;
        err_total++;
        report_and_stop();
    end
    initial begin
        {err_total, n_tests} = 0;
        px = 32'h61dd703b;
        {RST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = 0;
        {STANDARD_SELECT, SAMPLING_SELECT, SLEEP, ADDR_SELECT} = 0;
        {DETECTED_PAL, FIFO_OVERFLOW, CC_VALID, CC_DATA, FORMAT_SELECT} = 0;
        CLOCK_RATE_SELECT = 1'b1;
        FORMAT_SELECT = 2'h2; // one tick per pixel keeps the first line short
        for (int i = 0; i < 4; i++) exp_reg[i] = 32'h0;
        repeat (4) @(posedge CLK);
        check(FIELD_ODD, 1'b1, "field_odd");
        RST_N <= 1'b1;
        repeat (3) @(posedge CLK);
        cc = {24'h0, px[31:24]};
        CC_DATA <= px[31:24];
        CC_VALID <= 1'b1;
        @(posedge CLK);
        CC_VALID <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, i * 4, 32'h0);
            check(rd, exp_reg[i], "reg_reset");
        end
        apb(1'b0, 12'h00c, 32'h0);
        check(rd[14:8], `VDO_ADDR_LO, "slave_addr");
        apb(1'b1, 12'h010, 32'hff);
        apb(1'b0, 12'h010, 32'h0);
        check(er, 1'b1, "unmapped_err");
        check(rd, 32'h0, "unmapped_rd");
        for (int i = 0; i < 20000 && lines_done == 0; i++) @(posedge CLK);
        check(line_pixels, `VDO_HA_601, "active_pixels");
        check(first_y, cc, "caption_byte");
        check({VSYNC_N, ACTIVE_LINE_FLAG}, 2'b0, "vblank");
        check({FIELD_ODD, MEM_CTRL}, 5'h10, "field_mem");
        for (int i = 0; i < 4; i++) begin
            FORMAT_SELECT <= i[1:0];
            repeat (6) @(posedge CLK);
            check({Y_OE_N, C_OE_N, B_OE_N}, {1'b0, i < 2, i != 3}, "oe");
        end
        FORMAT_SELECT <= 2'b00;
        apb(1'b1, 12'h000, 32'hffff_ffc1);
        repeat (4) @(posedge CLK);
        check(B_OE_N, 1'b0, "reg_format");
        apb(1'b0, 12'h000, 32'h0);
        check(rd, exp_reg[0], "fmt_readback");
        apb(1'b1, 12'h000, 32'h0);
        STANDARD_SELECT <= 1'b1;
        ADDR_SELECT <= 1'b1;
        repeat (4) @(posedge CLK);
        apb(1'b0, 12'h00c, 32'h0);
        check({rd[14:8], rd[2]}, {`VDO_ADDR_HI, 1'b1}, "pal_addr");
        apb(1'b1, 12'h004, 32'h80);
        apb(1'b0, 12'h00c, 32'h0);
        check(rd[2], DETECTED_PAL, "auto_std");
        DETECTED_PAL <= 1'b1;
        STANDARD_SELECT <= 1'b0;
        repeat (4) @(posedge CLK);
        apb(1'b0, 12'h00c, 32'h0);
        check(rd[2], 1'b1, "auto_std_pal");
        apb(1'b1, 12'h004, 32'h0);
        FIFO_OVERFLOW <= 1'b1;
        @(posedge CLK);
        FIFO_OVERFLOW <= 1'b0;
        repeat (40) @(posedge CLK);
        check(STATUS_OUT, 1'b1, "overflow_set");
        apb(1'b1, 12'h00c, 32'h1);
        repeat (40) @(posedge CLK);
        check(STATUS_OUT, 1'b0, "overflow_clr");
        FIFO_OVERFLOW <= 1'b1;
        @(posedge CLK);
        FIFO_OVERFLOW <= 1'b0;
        apb(1'b1, 12'h008, 32'h1);
        repeat (40) @(posedge CLK);
        for (int i = 0; i < 16000 && HSYNC_N !== 1'b0; i++) @(posedge CLK);
        check(STATUS_OUT, 1'b0, "csync");
        apb(1'b0, 12'h008, 32'h0);
        check(rd, exp_reg[2], "osel_readback");
        rate();
        check(d >= -1 && d <= 1, 1'b1, "pclk_normal");
        CLOCK_RATE_SELECT <= 1'b0;
        repeat (40) @(posedge CLK);
        rate();
        check(d >= -1 && d <= 1, 1'b1, "pclk_double");
        CLOCK_RATE_SELECT <= 1'b1;
        SLEEP <= 1'b1;
        repeat (6) @(posedge CLK);
        check({Y_OE_N, C_OE_N, B_OE_N}, 3'b111, "sleep_oe");
        rate();
        apb(1'b0, 12'h00c, 32'h0);
        check(np, 0, "sleep_pclk");
        check(rd[3], 1'b1, "sleep_state");
        SLEEP <= 1'b0;
        repeat (40) @(posedge CLK);
        report_and_stop();
    end
endmodule

// ===== testbench/vdo_output_port_chk.sv
`timescale 1ns/100ps
module vdo_chk (
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic [11:0] PADDR,
    input wire logic        PSLVERR,
    input wire logic        SYSTEM_CLOCK_IN,
    input wire logic        SYSTEM_CLOCK_OUT,
    input wire logic        SLEEP,
    input wire logic        PIXEL_CLOCK_OUT,
    input wire logic        Y_OE_N,
    input wire logic        C_OE_N,
    input wire logic        B_OE_N,
    input wire logic        ACTIVE_PIXEL_FLAG,
    input wire logic        HSYNC_N
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    logic       pclk_q;
    logic       armed;
    logic       coe_q;
    logic [7:0] hs_ticks;
    // ticks seen while line sync is low; a pulse that sees the bus width
    // change is skipped, and byte formats spend two ticks per count
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pclk_q   <= 1'b0;
            armed    <= 1'b0;
            coe_q    <= 1'b1;
            hs_ticks <= 8'h00;
        end else begin
            pclk_q <= PIXEL_CLOCK_OUT;
            coe_q  <= C_OE_N;
            if (C_OE_N != coe_q)
                armed <= 1'b0;
            else if (HSYNC_N)
                armed <= 1'b1;
            if (HSYNC_N)
                hs_ticks <= 8'h00;
            else if (PIXEL_CLOCK_OUT && !pclk_q && hs_ticks != 8'hff)
                hs_ticks <= hs_ticks + 8'h01;
        end
    end
    sysclk_pass_a: assert property (
        SYSTEM_CLOCK_OUT == SYSTEM_CLOCK_IN)
        else $error("system clock output differs from input");
    blue_pair_a: assert property (
        !B_OE_N |-> !C_OE_N && !Y_OE_N)
        else $error("blue bus driven outside rgb mapping");
    sleep_oe_a: assert property (
        SLEEP [*4] |-> Y_OE_N && C_OE_N && B_OE_N)
        else $error("bus driven while asleep");
    sleep_clk_a: assert property (
        SLEEP [*5] |-> !PIXEL_CLOCK_OUT)
        else $error("pixel clock running while asleep");
    err_only_a: assert property (PSLVERR |-> PSEL && PENABLE)
        else $error("error flag outside access phase");
    unmapped_err_a: assert property (
        PSEL && PENABLE && PADDR > 12'h00c |-> PSLVERR)
        else $error("unmapped access not flagged");
    mapped_ok_a: assert property (
        PSEL && PENABLE && PADDR <= 12'h00c && PADDR[1:0] == 2'b00
        |-> !PSLVERR)
        else $error("mapped access flagged");
    tick_launch_a: assert property (
        $changed(ACTIVE_PIXEL_FLAG) |-> $rose(PIXEL_CLOCK_OUT))
        else $error("pixel flag moved off a pixel clock rise");
    hsync_len_a: assert property (
        $rose(HSYNC_N) && armed |-> hs_ticks == (C_OE_N ? 8'd128 : 8'd64))
        else $error("line sync pulse length wrong");
    sync_gap_a: assert property (
        ACTIVE_PIXEL_FLAG |-> HSYNC_N)
        else $error("active pixels overlap line sync");
endmodule
bind vdo_output_port vdo_chk u_vdo_chk (
    .CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PADDR(PADDR), .PSLVERR(PSLVERR), .SYSTEM_CLOCK_IN(SYSTEM_CLOCK_IN),
    .SYSTEM_CLOCK_OUT(SYSTEM_CLOCK_OUT), .SLEEP(SLEEP),
    .PIXEL_CLOCK_OUT(PIXEL_CLOCK_OUT), .Y_OE_N(Y_OE_N), .C_OE_N(C_OE_N),
    .B_OE_N(B_OE_N), .ACTIVE_PIXEL_FLAG(ACTIVE_PIXEL_FLAG),
    .HSYNC_N(HSYNC_N));

// ===== testbench/vdo_rx_model.sv
`timescale 1ns/100ps
module vdo_rx_model (
    input  wire logic        rst_n,
    input  wire logic        pclk,
    input  wire logic        active,
    input  wire logic [7:0]  y_data,
    output logic             sys_clk,
    output logic [31:0]      line_pixels,
    output logic [31:0]      lines_done,
    output logic [7:0]       first_y
);
    int run;
    // counters start known even if the reset edge at time zero is missed
    initial {line_pixels, lines_done} = 64'h0;
    // clock source, free running and unrelated in phase to the bench clock
    initial begin
        sys_clk = 1'b0;
        #17.3;
        forever #62.5 sys_clk = ~sys_clk;
    end
    // capture on the falling pixel clock so launch and capture never race
    always @(negedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            run = 0;
            line_pixels <= 32'h0;
            lines_done  <= 32'h0;
        end else if (active) begin
            if (run == 0)
                first_y <= y_data;
            run = run + 1;
        end else if (run != 0) begin
            line_pixels <= run;
            lines_done  <= lines_done + 32'h1;
            run = 0;
        end
    end
endmodule
